// ==== logic/cus_pkg.sv ====
// Constants, carrier types and helpers for the unread-status / mailbox-0 mask block.
// Assumes a single 40 MHz system clock and word-only AHB-Lite register access.
package cus_pkg;

    localparam int unsigned CUS_MBX_NUM = 16;
    localparam int unsigned CUS_MBX_W   = 4;
    localparam int unsigned CUS_ID_W    = 29;
    localparam int unsigned CUS_DATA_W  = 64;
    localparam int unsigned CUS_DLC_W   = 4;
    localparam int unsigned CUS_REG_W   = 16;
    localparam int unsigned CUS_OFS_W   = 8;
    localparam int unsigned CUS_EVT_W   = 3;

    // Byte offsets of the registers.
    localparam logic [7:0] CUS_OFS_UNREAD   = 8'h00;
    localparam logic [7:0] CUS_OFS_MASK_LO  = 8'h04;
    localparam logic [7:0] CUS_OFS_MASK_HI  = 8'h08;
    localparam logic [7:0] CUS_OFS_PENDING  = 8'h0C;
    localparam logic [7:0] CUS_OFS_CTRL     = 8'h10;
    localparam logic [7:0] CUS_OFS_MBX0_ID  = 8'h14;
    localparam logic [7:0] CUS_OFS_MBX_SEL  = 8'h18;
    localparam logic [7:0] CUS_OFS_DATA_LO  = 8'h1C;
    localparam logic [7:0] CUS_OFS_DATA_HI  = 8'h20;
    localparam logic [7:0] CUS_OFS_INT_STAT = 8'h24;
    localparam logic [7:0] CUS_OFS_INT_MASK = 8'h28;

    // Reset values and field layouts.
    localparam logic [15:0] CUS_RST_REG16   = 16'h0000;
    localparam logic [15:0] CUS_HI_WR_MASK  = 16'hE3FF;
    localparam logic [28:0] CUS_RST_ID      = 29'h00000000;
    localparam logic [3:0]  CUS_RST_SEL     = 4'h0;
    localparam logic [2:0]  CUS_RST_EVT     = 3'h0;
    localparam logic        CUS_RST_UMASK   = 1'b1;
    localparam int unsigned CUS_CTRL_UMASK  = 0;
    localparam logic [3:0]  CUS_MBX_FILTERED = 4'h0;

    // Interrupt status bit positions.
    localparam int unsigned CUS_EVT_OVERWRITE = 0;
    localparam int unsigned CUS_EVT_STORED    = 1;
    localparam int unsigned CUS_EVT_REJECT    = 2;

    // AHB-Lite encodings.
    localparam int unsigned CUS_HTRANS_ACT = 1;
    localparam logic        CUS_HRESP_OKAY = 1'b0;
    localparam logic [31:0] CUS_RD_ZERO    = 32'h00000000;

    typedef enum logic [1:0] {
        CUS_BUS_IDLE = 2'b00,
        CUS_BUS_WR   = 2'b01,
        CUS_BUS_RDW  = 2'b10,
        CUS_BUS_RDD  = 2'b11
    } cus_bus_st_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  ofs;
        logic [31:0] wdata;
    } cus_bus_req_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  mbx;
        logic [28:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } cus_rx_t;

    // Register view puts mailboxes 7..0 in bits 15..8 and 15..8 in bits 7..0.
    function automatic logic [15:0] cus_swap(input logic [15:0] v);
        cus_swap = {v[7:0], v[15:8]};
    endfunction

    // Expands the two mask registers into per-identifier-bit don't-care flags.
    function automatic logic [28:0] cus_dont_care(input logic [15:0] lo,
                                                  input logic [15:0] hi);
        cus_dont_care = {hi[7:0], hi[15:13], hi[9:8], lo[7:0], lo[15:8]};
    endfunction

endpackage

// ==== logic/cus_ahb_slave.sv ====
// AHB-Lite slave front end: turns bus transfers into register strobes.
// Assumes word transfers only; reads take one wait state, writes none.
`timescale 1ns/10ps
`default_nettype none
module cus_ahb_slave
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // AHB-Lite
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Register strobes
    output cus_pkg::cus_bus_req_t      req
);
    import cus_pkg::*;

    cus_bus_st_t st_ff;
    cus_bus_st_t nxt_st;
    logic [7:0]  ofs_ff;
    logic        take;

    assign take = hsel && htrans[CUS_HTRANS_ACT] && hready;

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            CUS_BUS_RDW: nxt_st = CUS_BUS_RDD;
            CUS_BUS_IDLE, CUS_BUS_WR, CUS_BUS_RDD:
            begin
                if (!take)
                    nxt_st = CUS_BUS_IDLE;
                else if (hwrite)
                    nxt_st = CUS_BUS_WR;
                else
                    nxt_st = CUS_BUS_RDW;
            end
            default: nxt_st = CUS_BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            st_ff <= CUS_BUS_IDLE;
        else
            st_ff <= nxt_st;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            ofs_ff <= CUS_OFS_UNREAD;
        else if (take)
            ofs_ff <= haddr[7:0];
    end

    // The wait state lets a read see every write that precedes it.
    assign hreadyout = (st_ff != CUS_BUS_RDW);
    assign hresp     = CUS_HRESP_OKAY;
    assign req.wr    = (st_ff == CUS_BUS_WR);
    assign req.rd    = (st_ff == CUS_BUS_RDW);
    assign req.ofs   = ofs_ff;
    assign req.wdata = hwdata;

endmodule // cus_ahb_slave
`default_nettype wire

// ==== logic/cus_accept_filter.sv ====
// Mailbox-0 acceptance compare with per-bit don't-care mask.
// Assumes the receiver presents identifiers already aligned to 29 bits.
`timescale 1ns/10ps
`default_nettype none
module cus_accept_filter
(
    // Compare inputs
    input  wire logic [28:0] rx_id,
    input  wire logic [28:0] ref_id,
    input  wire logic [15:0] mask_lo,
    input  wire logic [15:0] mask_hi,
    // Result
    output logic             match
);
    import cus_pkg::*;

    logic [28:0] dont_care;

    assign dont_care = cus_dont_care(mask_lo, mask_hi);         // see [R5] see [R6]
    assign match     = ((rx_id ^ ref_id) & ~dont_care) == '0;   // see [R4] see [R11]

endmodule // cus_accept_filter
`default_nettype wire

// ==== logic/cus_top.sv ====
// Unread-overwrite status, receive-pending flags and mailbox-0 acceptance mask.
// Assumes a receiver upstream that names a target mailbox per finished frame.
//
// How it works
// [R1] Overwrite of pending mailbox sets status; write-1 clears.
// [R2] Newer message replaces unread stored contents.
// [R3] Sixteen status bits, byte-swapped mailbox order, reset zero.
// [R4] Mask applies to mailbox 0 only.
// [R5] Low mask maps to identifier bits 15..0.
// [R6] High mask maps to identifier bits 28..16.
// [R7] High mask bits 12..10 read zero.
// [R8] Host writes zero to those reserved bits.
// [R9] Reception end sets the mailbox pending flag.
// [R10] Overrun request follows unread flag unless masked.
// [R11] Unmasked identifier bits must match exactly.
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cus_top
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // AHB-Lite register port
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Finished frames from the receiver
    input  wire cus_pkg::cus_rx_t      rx_msg,
    // Status towards the rest of the controller
    output logic [15:0]                receive_pending_flags,
    output logic                       unread_irq_flag,
    output logic                       overrun_class_irq_request,
    output logic                       irq
);
    import cus_pkg::*;

    cus_bus_req_t req;
    logic         match;
    logic         store;
    logic         reject;
    logic [15:0]  hit;
    logic [15:0]  wr_bits;
    logic [31:0]  rd_mux;

    logic [15:0]  unread_ff;
    logic [15:0]  nxt_unread;
    logic [15:0]  pending_ff;
    logic [15:0]  nxt_pending;
    logic [15:0]  mask_lo_ff;
    logic [15:0]  mask_hi_ff;
    logic         umask_ff;
    logic [28:0]  mbx0_id_ff;
    logic [3:0]   sel_ff;
    logic [2:0]   istat_ff;
    logic [2:0]   nxt_istat;
    logic [2:0]   imask_ff;
    logic [2:0]   evt;
    logic [31:0]  hrdata_ff;
    logic         uflag_ff;
    logic         ovr_ff;
    logic         irq_ff;

    logic [63:0]  mbx_data [CUS_MBX_NUM];
    logic [3:0]   mbx_dlc  [CUS_MBX_NUM];

    cus_ahb_slave u_slave
    (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .req       (req)
    );

    cus_accept_filter u_filter
    (
        .rx_id   (rx_msg.id),
        .ref_id  (mbx0_id_ff),
        .mask_lo (mask_lo_ff),
        .mask_hi (mask_hi_ff),
        .match   (match)
    );

    // Only mailbox 0 is filtered here; others arrive already chosen.
    assign reject  = rx_msg.valid && rx_msg.mbx == CUS_MBX_FILTERED && !match; // see [R4]
    assign store   = rx_msg.valid && !reject;
    assign hit     = store ? (16'h0001 << rx_msg.mbx) : CUS_RST_REG16;
    // Incoming writes are in register order; convert to mailbox order.
    assign wr_bits = cus_swap(req.wdata[15:0]);

    // Set wins over a write-1 clear in the same cycle.
    assign nxt_unread = (unread_ff & ~((req.wr && req.ofs == CUS_OFS_UNREAD) ?
                        wr_bits : CUS_RST_REG16)) | (hit & pending_ff);    // see [R1]
    assign nxt_pending = (pending_ff & ~((req.wr && req.ofs == CUS_OFS_PENDING) ?
                         wr_bits : CUS_RST_REG16)) | hit;                  // see [R9]

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            unread_ff <= CUS_RST_REG16;                                   // see [R3]
        else
            unread_ff <= nxt_unread;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            pending_ff <= CUS_RST_REG16;
        else
            pending_ff <= nxt_pending;
    end

    // Message store is RAM-like and has no reset; a stored frame always
    // overwrites, so an unread earlier one is lost on purpose.
    always_ff @(posedge sys_clk)
    begin
        if (store)
        begin
            mbx_data[rx_msg.mbx] <= rx_msg.data;                          // see [R2]
            mbx_dlc[rx_msg.mbx]  <= rx_msg.dlc;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            mask_lo_ff <= CUS_RST_REG16;
            mask_hi_ff <= CUS_RST_REG16;                                  // see [R11]
        end
        else if (req.wr && req.ofs == CUS_OFS_MASK_LO)
            mask_lo_ff <= req.wdata[15:0];
        else if (req.wr && req.ofs == CUS_OFS_MASK_HI)
            // Reserved bits are dropped even if the host breaks its side.
            mask_hi_ff <= req.wdata[15:0] & CUS_HI_WR_MASK;               // see [R7] see [R8]
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            umask_ff   <= CUS_RST_UMASK;
            mbx0_id_ff <= CUS_RST_ID;
            sel_ff     <= CUS_RST_SEL;
            imask_ff   <= CUS_RST_EVT;
        end
        else if (req.wr)
        begin
            case (req.ofs)
                CUS_OFS_CTRL:     umask_ff   <= req.wdata[CUS_CTRL_UMASK];
                CUS_OFS_MBX0_ID:  mbx0_id_ff <= req.wdata[28:0];
                CUS_OFS_MBX_SEL:  sel_ff     <= req.wdata[3:0];
                CUS_OFS_INT_MASK: imask_ff   <= req.wdata[2:0];
                default:          sel_ff     <= sel_ff;
            endcase
        end
    end

    assign evt[CUS_EVT_OVERWRITE] = |(hit & pending_ff);
    assign evt[CUS_EVT_STORED]    = store;
    assign evt[CUS_EVT_REJECT]    = reject;

    // A read of the status clears it, but an event in that cycle survives.
    assign nxt_istat = (istat_ff & ~((req.rd && req.ofs == CUS_OFS_INT_STAT) ?
                       istat_ff : CUS_RST_EVT)) | evt;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            istat_ff <= CUS_RST_EVT;
        else
            istat_ff <= nxt_istat;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            uflag_ff <= 1'b0;
            ovr_ff   <= 1'b0;
            irq_ff   <= 1'b0;
        end
        else
        begin
            uflag_ff <= |nxt_unread;
            ovr_ff   <= (|nxt_unread) && !umask_ff;                       // see [R10]
            irq_ff   <= |(nxt_istat & imask_ff);
        end
    end

    always_comb
    begin
        rd_mux = CUS_RD_ZERO;
        case (req.ofs)
            CUS_OFS_UNREAD:   rd_mux[15:0] = cus_swap(unread_ff);         // see [R3]
            CUS_OFS_MASK_LO:  rd_mux[15:0] = mask_lo_ff;
            CUS_OFS_MASK_HI:  rd_mux[15:0] = mask_hi_ff & CUS_HI_WR_MASK; // see [R7]
            CUS_OFS_PENDING:  rd_mux[15:0] = cus_swap(pending_ff);
            CUS_OFS_CTRL:     rd_mux[CUS_CTRL_UMASK] = umask_ff;
            CUS_OFS_MBX0_ID:  rd_mux[28:0] = mbx0_id_ff;
            CUS_OFS_MBX_SEL:  rd_mux[3:0]  = sel_ff;
            CUS_OFS_DATA_LO:  rd_mux = mbx_data[sel_ff][31:0];
            CUS_OFS_DATA_HI:  rd_mux = mbx_data[sel_ff][63:32];
            CUS_OFS_INT_STAT: rd_mux[2:0]  = istat_ff;
            CUS_OFS_INT_MASK: rd_mux[2:0]  = imask_ff;
            default:          rd_mux = CUS_RD_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            hrdata_ff <= CUS_RD_ZERO;
        else if (req.rd)
            hrdata_ff <= rd_mux;
    end

    assign hrdata                    = hrdata_ff;
    assign receive_pending_flags     = cus_swap(pending_ff);
    assign unread_irq_flag           = uflag_ff;
    assign overrun_class_irq_request = ovr_ff;
    assign irq                       = irq_ff;

    // Checks that travel with the logic.
    logic [3:0] mbx_q;
    always_ff @(posedge sys_clk)
    begin
        mbx_q <= rx_msg.mbx;
    end

    sequence s_overwrite;
        store && pending_ff[rx_msg.mbx];
    endsequence

    sequence s_read_taken;
        hsel && htrans[CUS_HTRANS_ACT] && !hwrite && hready;
    endsequence

    sequence s_read_wait;
        !hreadyout && req.rd;
    endsequence

    property p_unread_set;
        @(posedge sys_clk) disable iff (reset)
        s_overwrite |=> unread_ff[mbx_q];
    endproperty
    a_unread_set: assert property (p_unread_set) // see [R1]
        else $error("overwrite did not set unread status");

    property p_unread_hold;
        @(posedge sys_clk) disable iff (reset)
        !(req.wr && req.ofs == CUS_OFS_UNREAD)
        |=> (unread_ff & $past(unread_ff)) == $past(unread_ff);
    endproperty
    a_unread_hold: assert property (p_unread_hold) // see [R1]
        else $error("unread status cleared without a write");

    property p_replace;
        logic [63:0] d;
        @(posedge sys_clk) disable iff (reset)
        (store, d = rx_msg.data) |=> mbx_data[mbx_q] == d;
    endproperty
    a_replace: assert property (p_replace) // see [R2]
        else $error("stored data not replaced");

    property p_status_view;
        @(posedge sys_clk) disable iff (reset)
        req.rd && req.ofs == CUS_OFS_UNREAD
        |=> hrdata[15:8] == $past(unread_ff[7:0]) && hrdata[7:0] == $past(unread_ff[15:8]);
    endproperty
    a_status_view: assert property (p_status_view) // see [R3]
        else $error("unread status bit order wrong");

    property p_filter_reject;
        @(posedge sys_clk) disable iff (reset)
        rx_msg.valid && rx_msg.mbx == CUS_MBX_FILTERED
        && ((rx_msg.id ^ mbx0_id_ff) & ~cus_dont_care(mask_lo_ff, mask_hi_ff)) != '0
        |=> !pending_ff[0] || $past(pending_ff[0]);
    endproperty
    a_filter_reject: assert property (p_filter_reject) // see [R4]
        else $error("mailbox 0 accepted a mismatching identifier");

    property p_mask_lo_map;
        @(posedge sys_clk) disable iff (reset)
        rx_msg.valid && rx_msg.mbx == CUS_MBX_FILTERED && mask_lo_ff[15]
        && (rx_msg.id ^ mbx0_id_ff) == 29'h00000080 |-> match;
    endproperty
    a_mask_lo_map: assert property (p_mask_lo_map) // see [R5]
        else $error("low mask bit 15 did not free identifier bit 7");

    property p_mask_hi_map;
        @(posedge sys_clk) disable iff (reset)
        rx_msg.valid && mask_hi_ff[7] && !mask_hi_ff[6]
        && (rx_msg.id ^ mbx0_id_ff) == 29'h10000000 |-> match;
    endproperty
    a_mask_hi_map: assert property (p_mask_hi_map) // see [R6]
        else $error("high mask bit 7 did not free identifier bit 28");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (reset)
        req.rd && req.ofs == CUS_OFS_MASK_HI |=> hrdata[12:10] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // see [R7]
        else $error("reserved high mask bits read nonzero");

    property p_pending_set;
        @(posedge sys_clk) disable iff (reset)
        store |=> pending_ff[mbx_q];
    endproperty
    a_pending_set: assert property (p_pending_set) // see [R9]
        else $error("reception end did not set pending flag");

    property p_ovr_req;
        @(posedge sys_clk) disable iff (reset)
        ##1 overrun_class_irq_request == (unread_irq_flag && !$past(umask_ff));
    endproperty
    a_ovr_req: assert property (p_ovr_req) // see [R10]
        else $error("overrun request disagrees with flag and mask");

    property p_exact_match;
        @(posedge sys_clk) disable iff (reset)
        mask_lo_ff == CUS_RST_REG16 && mask_hi_ff == CUS_RST_REG16
        |-> match == (rx_msg.id == mbx0_id_ff);
    endproperty
    a_exact_match: assert property (p_exact_match) // see [R11]
        else $error("clear mask must compare every identifier bit");

    property p_read_timing;
        @(posedge sys_clk) disable iff (reset)
        s_read_taken |=> s_read_wait ##1 (hreadyout && hrdata == $past(rd_mux));
    endproperty
    a_read_timing: assert property (p_read_timing)
        else $error("read answer not after one wait state");

endmodule // cus_top
`default_nettype wire

// ==== verification/cus_rx_src.sv ====
// Receiver-side model: presents finished frames to the block as one-cycle strobes.
// Assumes the bench calls send from a single process, one frame at a time.
`timescale 1ns/10ps
`default_nettype none
module cus_rx_src
(
    // Clock
    input  wire logic           sys_clk,
    // Finished frames
    output var cus_pkg::cus_rx_t rx_msg
);
    import cus_pkg::*;

    initial rx_msg = '0;

    // Between frames every field carries the inverse of the last frame, and the inverse
    // clears valid, so stale contents can never pass for a fresh frame.
    task automatic send(input logic [3:0] mbx, input logic [28:0] id, input logic [63:0] d);
        cus_rx_t m;
        m = '{1'b1, mbx, id, 4'h8, d};
        @(posedge sys_clk);
        rx_msg <= m;
        @(posedge sys_clk);
        rx_msg <= ~m;
    endtask
endmodule // cus_rx_src
`default_nettype wire

// ==== verification/can_unread_status_and_rx_mask_test.sv ====
// Self-checking bench: AHB-Lite host, frame source and a reference model of the block.
// Assumes the design and cus_rx_src are compiled first.
`timescale 1ns/10ps
`default_nettype none
module can_unread_status_and_rx_mask_test;
    import cus_pkg::*;

    logic             sys_clk  = 1'b0;
    logic             reset    = 1'b1;
    logic             hsel     = 1'b0;
    logic [31:0]      haddr    = 32'h0;
    logic [1:0]       htrans   = 2'b00;
    logic             hwrite   = 1'b0;
    logic [31:0]      hwdata   = 32'h0;
    wire logic [31:0] hrdata;
    wire logic        hreadyout;
    wire logic        hresp;
    wire cus_rx_t     rx_msg;
    wire logic [15:0] pend_flags;
    wire logic        unread_flag;
    wire logic        ovr_req;
    wire logic        irq;
    int               num_errors = 0;
    int               n_checks   = 0;
    logic [15:0]      m_pend     = 16'h0;
    logic [15:0]      m_unr      = 16'h0;
    logic [63:0]      m_data [16];
    logic [2:0]       m_ist      = 3'h0;
    logic [28:0]      m_ref      = 29'h0;
    logic [15:0]      m_lo       = 16'h0;
    logic [15:0]      m_hi       = 16'h0;
    logic [31:0]      v;

    always #12.5 sys_clk = ~sys_clk;

    cus_top uut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_msg(rx_msg),
        .receive_pending_flags(pend_flags), .unread_irq_flag(unread_flag),
        .overrun_class_irq_request(ovr_req), .irq(irq));

    cus_rx_src src (.sys_clk(sys_clk), .rx_msg(rx_msg));

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // Ready and read data are taken in the rising edge's own time step, before the
    // slave's registers move, so the bench sees exactly what that edge samples.
    task automatic wait_ready(output logic [31:0] rd);
        int t;
        t = 0;
        do
        begin
            @(posedge sys_clk);
            t++;
        end
        while (hreadyout !== 1'b1 && t < 20);
        if (t >= 20)
            chk("hreadyout", 64'h1, {63'h0, hreadyout});
        rd = hrdata;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        logic [31:0] r;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        wait_ready(r);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready(rd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(n, {32'h0, e}, {32'h0, r});
        chk("hresp", 64'h0, {63'h0, hresp});
    endtask

    // Mailbox order to register order; the swap is its own inverse.
    function automatic logic [15:0] reg_order(input logic [15:0] x);
        return {x[7:0], x[15:8]};
    endfunction

    function automatic logic [28:0] dont_care();
        return {m_hi[7:0], m_hi[15:13], m_hi[9:8], m_lo[7:0], m_lo[15:8]};
    endfunction

    task automatic frame(input logic [3:0] mb, input logic [28:0] id);
        logic [63:0] d;
        d = {$urandom, $urandom};
        src.send(mb, id, d);
        if (mb != 4'h0 || ((id ^ m_ref) & ~dont_care()) == 29'h0)
        begin
            m_ist[0]   = m_ist[0] | m_pend[mb];
            m_unr[mb]  = m_unr[mb] | m_pend[mb];
            m_pend[mb] = 1'b1;
            m_data[mb] = d;
            m_ist[1]   = 1'b1;
        end
        else
            m_ist[2] = 1'b1;
        @(posedge sys_clk);
    endtask

    task automatic check_state();
        rdc(CUS_OFS_PENDING, {16'h0, reg_order(m_pend)}, "pending");
        rdc(CUS_OFS_UNREAD, {16'h0, reg_order(m_unr)}, "unread");
        chk("pending_port", {48'h0, reg_order(m_pend)}, {48'h0, pend_flags});
        chk("unread_flag", {63'h0, |m_unr}, {63'h0, unread_flag});
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        summarize();
    end

    initial
    begin
        v = $urandom(32'h413A);
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        rdc(CUS_OFS_UNREAD, 32'h0, "unread_rst");
        rdc(CUS_OFS_MASK_LO, 32'h0, "mask_lo_rst");
        rdc(CUS_OFS_MASK_HI, 32'h0, "mask_hi_rst");
        rdc(CUS_OFS_CTRL, 32'h1, "ctrl_rst");
        rdc(8'h40, 32'h0, "unmapped");
        // With a clear mask one differing identifier bit must turn the frame away.
        frame(4'h0, 29'h00000080);
        check_state();
        // The host keeps the reserved high-mask bits at zero on every write.
        wr(CUS_OFS_MASK_HI, 32'h0000E3FF);
        rdc(CUS_OFS_MASK_HI, 32'h0000E3FF, "mask_hi_rsvd");
        m_ref = 29'($urandom);
        // Low bit 15 and high bit 7 are forced so the single-bit mapping checks fire.
        m_lo  = 16'($urandom) | 16'h8000;
        m_hi  = (16'($urandom) & 16'hE3BF) | 16'h0080;
        wr(CUS_OFS_MBX0_ID, {3'h0, m_ref});
        wr(CUS_OFS_MASK_LO, {16'h0, m_lo});
        wr(CUS_OFS_MASK_HI, {16'h0, m_hi});
        rdc(CUS_OFS_MASK_LO, {16'h0, m_lo}, "mask_lo");
        rdc(CUS_OFS_MASK_HI, {16'h0, m_hi}, "mask_hi");
        for (int b = 0; b < 29; b++)
        begin
            frame(4'h0, m_ref ^ (29'h1 << b));
            check_state();
            wr(CUS_OFS_PENDING, 32'h0000FFFF);
            m_pend = 16'h0;
        end
        frame(4'h0, m_ref);
        frame(4'h5, ~m_ref);
        check_state();
        rdc(CUS_OFS_INT_STAT, {29'h0, m_ist}, "int_stat");
        m_ist = 3'h0;
        wr(CUS_OFS_PENDING, 32'h0000FFFF);
        m_pend = 16'h0;
        for (int mb = 0; mb < 16; mb++)
        begin
            frame(4'(mb), m_ref);
            frame(4'(mb), m_ref);
            wr(CUS_OFS_MBX_SEL, mb);
            rdc(CUS_OFS_DATA_LO, m_data[mb][31:0], "data_lo");
            rdc(CUS_OFS_DATA_HI, m_data[mb][63:32], "data_hi");
            check_state();
        end
        chk("ovr_masked", 64'h0, {63'h0, ovr_req});
        chk("irq_masked", 64'h0, {63'h0, irq});
        wr(CUS_OFS_CTRL, 32'h0);
        wr(CUS_OFS_INT_MASK, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk("ovr_req", 64'h1, {63'h0, ovr_req});
        chk("irq", 64'h1, {63'h0, irq});
        rdc(CUS_OFS_INT_STAT, {29'h0, m_ist}, "int_stat");
        m_ist = 3'h0;
        rdc(CUS_OFS_INT_STAT, 32'h0, "int_stat_clr");
        repeat (2) @(posedge sys_clk);
        chk("irq_clr", 64'h0, {63'h0, irq});
        v = $urandom;
        wr(CUS_OFS_UNREAD, {16'h0, v[15:0]});
        m_unr = m_unr & ~reg_order(v[15:0]);
        check_state();
        wr(CUS_OFS_UNREAD, 32'h0000FFFF);
        m_unr = 16'h0;
        repeat (2) @(posedge sys_clk);
        check_state();
        chk("ovr_clr", 64'h0, {63'h0, ovr_req});
        // A second reset in mid-run must drop the pending flags left set above.
        reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        m_pend = 16'h0;
        m_unr  = 16'h0;
        m_ist  = 3'h0;
        m_ref  = 29'h0;
        m_lo   = 16'h0;
        m_hi   = 16'h0;
        check_state();
        rdc(CUS_OFS_CTRL, 32'h1, "ctrl_rst2");
        rdc(CUS_OFS_MASK_HI, 32'h0, "mask_hi_rst2");
        summarize();
    end
endmodule // can_unread_status_and_rx_mask_test
`default_nettype wire
